/* File: logic/rsc_pkg.sv */
package rsc_pkg;
  // register byte addresses; the cause register index is 0xEF, four bytes per word
  localparam logic [11:0] CAUSE_IDX = 12'h0EF;
  localparam logic [11:0] CAUSE_ADDR = 12'h3BC;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h3C0;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h3C4;
  // cause register field positions
  localparam int BIT_PIN = 0;
  localparam int BIT_POR = 1;
  localparam int BIT_MCD = 2;
  localparam int BIT_WDT = 3;
  localparam int BIT_SW = 4;
  localparam int BIT_CMP = 5;
  localparam int BIT_FERR = 6;
  localparam int BIT_USB = 7;
  // value after power-on: only the power-on flag set
  localparam logic [7:0] CAUSE_RESET = 8'h02;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // user code limits for the two flash sizes
  localparam logic [15:0] FLASH_TOP_32K = 16'h7FFF;
  localparam logic [15:0] FLASH_TOP_64K = 16'hFBFF;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // system reset hold time
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_DELAY_NS = 5000;
  localparam int RESET_HOLD_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // flash access kinds
  typedef enum logic [1:0] {
    FA_NONE = 2'b00,
    FA_XWRITE = 2'b01,
    FA_CREAD = 2'b10,
    FA_FETCH = 2'b11
  } rsc_fkind_e;
  // block state
  typedef enum logic {
    RS_RUN = 1'b0,
    RS_HOLD = 1'b1
  } rsc_state_e;
  // flash access presented by the flash controller
  typedef struct packed {
    logic valid;
    rsc_fkind_e kind;
    logic [15:0] addr;
    logic wr_en;
    logic secure_deny;
  } rsc_flash_s;
  // bus function controller status
  typedef struct packed {
    logic ctrl_en;
    logic bus_reset;
    logic vbus_level;
    logic vbus_pol;
  } rsc_usb_s;
endpackage

/* File: logic/rsc_hold_timer.sv */
`timescale 1ns/1ps
module rsc_hold_timer #(
  parameter int CYCLES = 625
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ZERO = '0;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // load on start, count down to zero
  assign cnt_d = start ? LOAD : (cnt_q != ZERO) ? cnt_q - CW'(1) : cnt_q;
  assign busy = (cnt_q != ZERO);

  // counter register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: logic/rsc_reset_cause.sv */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - enabled external-move write above code limit resets instead of writing.
// - code-move read above code limit resets the system.
// - instruction fetch above code limit resets the system.
// - flash access denied by security setting resets the system.
// - flash write or erase with supply monitor off is blocked and resets.
// - flash fault flag reads one only after a flash error reset; read-only.
// - internal resets never drive the external reset pin.
// - writing one to soft reset flag resets at once; zero does nothing.
// - soft reset flag reads one only after a software reset.
// - bus reset flag write selects bus source; read shows last cause.
// - selected and enabled bus function resets on bus reset signaling.
// - selected bus function resets when supply sense matches chosen polarity.
// - bus reset flag reads one after either bus function reset.
// - writing one to comparator flag makes comparator low a reset source.
// - clock loss flag write enables detector; reads one after its reset.
module rsc_reset_cause #(
  parameter bit FLASH_IS_64K = 1'b1,
  parameter int HOLD_CYCLES = rsc_pkg::RESET_HOLD_CYC
) (
  // clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash controller
  input wire rsc_pkg::rsc_flash_s flash_i,
  input wire logic supply_mon_en_i,
  output logic flash_allow_o,
  // bus function controller
  input wire rsc_pkg::rsc_usb_s usb_i,
  // other reset sources
  input wire logic cmp_below_i,
  input wire logic clock_missing_i,
  input wire logic vdd_below_i,
  input wire logic wdt_expire_i,
  input wire logic pin_reset_i,
  // reset outputs
  output logic sys_reset_o,
  output logic rst_pin_oe_o,
  // interrupt
  output logic irq_o
);
  // block state and registers
  rsc_pkg::rsc_state_e state_q;
  rsc_pkg::rsc_state_e state_d;
  logic [7:0] cause_q;
  logic [7:0] sel_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [11:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // flash limit and fault detection
  // the limit is fixed per build by the flash size parameter, so the compare
  // is against a constant and one comparator is shared by all access kinds
  // a fault is judged in the same cycle the access is presented, so the
  // flash controller never starts a faulting write or erase
  // the security deny line comes from the flash controller already decoded
  wire [15:0] code_top = FLASH_IS_64K ? rsc_pkg::FLASH_TOP_64K : rsc_pkg::FLASH_TOP_32K;
  wire above_top = flash_i.addr > code_top;
  wire fa_xwrite = flash_i.valid && (flash_i.kind == rsc_pkg::FA_XWRITE) && flash_i.wr_en;
  wire fa_cread = flash_i.valid && (flash_i.kind == rsc_pkg::FA_CREAD);
  wire fa_fetch = flash_i.valid && (flash_i.kind == rsc_pkg::FA_FETCH);
  wire ferr_write_top = fa_xwrite && above_top;
  wire ferr_read_top = fa_cread && above_top;
  wire ferr_fetch_top = fa_fetch && above_top;
  wire ferr_secure = flash_i.valid && flash_i.secure_deny;
  wire ferr_supply = fa_xwrite && !supply_mon_en_i;
  wire flash_fault = ferr_write_top | ferr_read_top | ferr_fetch_top | ferr_secure | ferr_supply;

  // faulting or held accesses are not carried out
  // no access proceeds while the system is held in reset
  assign flash_allow_o = flash_i.valid && !flash_fault && (state_q == rsc_pkg::RS_RUN);

  // write path decode
  // a write is acted on once both halves are held and no response is pending,
  // which keeps the register update and bvalid on the same edge
  // only byte lane 0 carries register bits; other lanes are ignored
  // an unmapped address still gets a response so the master never stalls
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire wr_cause = wr_go && (awaddr_q == rsc_pkg::CAUSE_ADDR) && wstrb_q[0];
  wire wr_stat = wr_go && (awaddr_q == rsc_pkg::IRQ_STAT_ADDR) && wstrb_q[0];
  wire wr_mask = wr_go && (awaddr_q == rsc_pkg::IRQ_MASK_ADDR) && wstrb_q[0];
  wire wr_hit = (awaddr_q == rsc_pkg::CAUSE_ADDR) || (awaddr_q == rsc_pkg::IRQ_STAT_ADDR) ||
                (awaddr_q == rsc_pkg::IRQ_MASK_ADDR);
  wire [7:0] wbyte = wdata_q[7:0];

  // software requests: a zero written to these bits does nothing
  // the soft request is a strobe from the write, never a stored bit,
  // so a later write with bit4 clear cannot trigger it again
  // bit0 written high forces a reset that is recorded as power-on
  wire sw_req = wr_cause && wbyte[rsc_pkg::BIT_SW];
  wire pin_req = wr_cause && wbyte[rsc_pkg::BIT_PIN];

  // bus function source
  // bus signalling only counts while the controller is enabled
  // the supply sense event is a level compare, so a matching level keeps
  // requesting; the select clears on reset, which stops a reset loop
  wire usb_sig = usb_i.ctrl_en && usb_i.bus_reset;
  wire usb_vbus = usb_i.vbus_level == usb_i.vbus_pol;
  wire usb_ev = sel_q[rsc_pkg::BIT_USB] && (usb_sig || usb_vbus);

  // event vector in cause-register layout
  // each optional source is gated by its select bit
  logic [7:0] ev;
  always_comb begin
    ev = 8'h00;
    ev[rsc_pkg::BIT_PIN] = pin_reset_i;
    ev[rsc_pkg::BIT_POR] = pin_req || (sel_q[rsc_pkg::BIT_POR] && vdd_below_i);
    ev[rsc_pkg::BIT_MCD] = sel_q[rsc_pkg::BIT_MCD] && clock_missing_i;
    ev[rsc_pkg::BIT_WDT] = wdt_expire_i;
    ev[rsc_pkg::BIT_SW] = sw_req;
    ev[rsc_pkg::BIT_CMP] = sel_q[rsc_pkg::BIT_CMP] && cmp_below_i;
    ev[rsc_pkg::BIT_FERR] = flash_fault;
    ev[rsc_pkg::BIT_USB] = usb_ev;
  end

  // lowest set bit wins so a single flag is captured
  // two sources on one edge would otherwise set two flags; the lowest bit
  // wins so the cause byte stays one-hot
  wire [7:0] pick = ev & (~ev + 8'h01);
  wire fire = (state_q == rsc_pkg::RS_RUN) && (ev != 8'h00);
  wire hold_busy;

  // reset hold timer
  // loaded on the firing edge and counts down; the hold lasts one cycle
  // longer than the count because the state leaves hold on the edge
  // after the counter reaches zero
  rsc_hold_timer #(
    .CYCLES(HOLD_CYCLES)
  ) u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(fire),
    .busy(hold_busy)
  );

  // state sequencing
  // run: watch for events; hold: keep system reset high until the timer ends
  // events seen during the hold are dropped, not queued, since the system is
  // already going through reset
  always_comb begin
    state_d = state_q;
    case (state_q)
      rsc_pkg::RS_RUN: begin
        if (fire) begin
          state_d = rsc_pkg::RS_HOLD;
        end
      end
      rsc_pkg::RS_HOLD: begin
        if (!hold_busy) begin
          state_d = rsc_pkg::RS_RUN;
        end
      end
      default: begin
        state_d = rsc_pkg::RS_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= rsc_pkg::RS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // system reset is held while the timer runs; the pin is never driven
  // internal sources reset the system through sys_reset_o and leave the
  // pin to the board
  assign sys_reset_o = (state_q == rsc_pkg::RS_HOLD);
  assign rst_pin_oe_o = 1'b0;

  // cause capture: one-hot on each generated reset, read-only to software
  // software writes to the same address land in the select bits below
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= rsc_pkg::CAUSE_RESET;
    end else if (fire) begin
      cause_q <= pick;
    end
  end

  // source selects kept apart from the causes, cleared by each system reset
  // clearing them keeps a level source from firing again as soon as the
  // hold ends; software re-arms them after reading the cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= rsc_pkg::SEL_RESET;
    end else if (fire) begin
      sel_q <= rsc_pkg::SEL_RESET;
    end else if (wr_cause) begin
      sel_q[rsc_pkg::BIT_USB] <= wbyte[rsc_pkg::BIT_USB];
      sel_q[rsc_pkg::BIT_CMP] <= wbyte[rsc_pkg::BIT_CMP];
      sel_q[rsc_pkg::BIT_MCD] <= wbyte[rsc_pkg::BIT_MCD];
      sel_q[rsc_pkg::BIT_POR] <= wbyte[rsc_pkg::BIT_POR];
    end
  end

  // interrupt status: sticky, write one to clear, a new event wins
  // the layout mirrors the cause byte so software can find the source
  // without reading the cause register; no event is lost to a clear
  wire [7:0] stat_set = fire ? pick : 8'h00;
  wire [7:0] stat_clr = wr_stat ? wbyte : 8'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 8'h00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~stat_clr) | stat_set;
    end
  end

  // interrupt mask
  // writing zero masks a source without touching its status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= 8'h00;
    end else if (wr_mask) begin
      irq_mask_q <= wbyte;
    end
  end

  // plain level: drops as soon as the status bit is cleared or masked
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // write address and data are taken independently
  // each half stalls while it is held or a response waits, so at most
  // one write is in flight and the halves pair up in order
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 12'h000;
    // the address half is kept until the paired data half arrives
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    // data and strobes are kept until the address half arrives
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  // the response stays until bready; a new write cannot start before that
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= rsc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read decode
  // reads have no side effects, so the address is decoded straight off the
  // bus and the data registered with rvalid
  // unmapped reads return zero with an error response
  wire rd_go = s_axi_arvalid && !rvalid_q;
  wire rd_cause = (s_axi_araddr == rsc_pkg::CAUSE_ADDR);
  wire rd_stat = (s_axi_araddr == rsc_pkg::IRQ_STAT_ADDR);
  wire rd_mask = (s_axi_araddr == rsc_pkg::IRQ_MASK_ADDR);
  wire [7:0] rd_byte = rd_cause ? cause_q :
                       rd_stat ? irq_stat_q :
                       rd_mask ? irq_mask_q : 8'h00;
  wire rd_hit = rd_cause || rd_stat || rd_mask;

  assign s_axi_arready = !rvalid_q;

  // read data registered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= rsc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_hit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

/* File: testbench/rsc_flash_model.sv */
`timescale 1ns/1ps
module rsc_flash_model (
  // clock
  input wire logic aclk,
  // command from the bench
  input wire logic go,
  input wire rsc_pkg::rsc_flash_s cmd,
  // design side
  input wire logic allow,
  input wire logic sys_reset,
  output rsc_pkg::rsc_flash_s flash = '0
);
  // hold an access until granted or reset hits, then leave scrambled lines behind
  always @(posedge aclk) begin
    if (go)
      flash <= cmd;
    else if (flash.valid && (allow || sys_reset))
      flash <= {1'b0, ~flash[19:0]};
  end
endmodule

/* File: testbench/rsc_reset_cause_properties.sv */
`timescale 1ns/1ps
module rsc_reset_cause_properties #(
  parameter bit FLASH_IS_64K = 1'b1,
  parameter int HOLD_CYCLES = 625
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // flash and reset outputs
  input wire rsc_pkg::rsc_flash_s flash_i,
  input wire logic supply_mon_en_i,
  input wire logic flash_allow_o,
  input wire logic sys_reset_o,
  input wire logic rst_pin_oe_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // flash access and soft write decode
  wire hi = flash_i.addr > (FLASH_IS_64K ? rsc_pkg::FLASH_TOP_64K : rsc_pkg::FLASH_TOP_32K);
  wire fv = flash_i.valid && !sys_reset_o;
  wire xw = flash_i.kind == rsc_pkg::FA_XWRITE && flash_i.wr_en;
  wire sw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == rsc_pkg::CAUSE_ADDR && s_axi_wstrb[0] && s_axi_wdata[4];
  // cycles spent in the current hold
  int hold_q;
  always_ff @(posedge aclk) hold_q <= (!aresetn || !sys_reset_o) ? 0 : hold_q + 1;
  a_xwrite_high: assert property (fv && xw && hi |=> sys_reset_o)
    else $error("write above code limit gave no reset");
  a_cread_high: assert property (fv && flash_i.kind == rsc_pkg::FA_CREAD && hi |=> sys_reset_o)
    else $error("code read above limit gave no reset");
  a_fetch_high: assert property (fv && flash_i.kind == rsc_pkg::FA_FETCH && hi |=> sys_reset_o)
    else $error("fetch above limit gave no reset");
  a_deny_reset: assert property (fv && flash_i.secure_deny |=> sys_reset_o)
    else $error("denied access gave no reset");
  a_nomon_block: assert property (flash_i.valid && xw && !supply_mon_en_i |-> !flash_allow_o)
    else $error("write allowed with monitor off");
  a_hold_block: assert property (sys_reset_o |-> !flash_allow_o)
    else $error("access allowed during reset");
  a_pin_idle: assert property (rst_pin_oe_o == 1'b0)
    else $error("reset pin driven");
  a_soft_reset: assert property (sw && !sys_reset_o |-> ##[1:2] sys_reset_o)
    else $error("soft write gave no reset");
  a_hold_len: assert property ($fell(sys_reset_o) |-> hold_q == HOLD_CYCLES + 1)
    else $error("reset hold length wrong");
  a_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  c_reset: cover property ($rose(sys_reset_o));
  c_soft: cover property (sw);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == rsc_pkg::RESP_SLVERR);
endmodule
bind rsc_reset_cause rsc_reset_cause_properties #(.FLASH_IS_64K(FLASH_IS_64K),
  .HOLD_CYCLES(HOLD_CYCLES)) i_rsc_reset_cause_properties (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .flash_i(flash_i), .supply_mon_en_i(supply_mon_en_i), .flash_allow_o(flash_allow_o),
  .sys_reset_o(sys_reset_o), .rst_pin_oe_o(rst_pin_oe_o));

/* File: testbench/rsc_reset_cause_tb.sv */
`timescale 1ns/1ps
module rsc_reset_cause_tb;
  localparam int HOLD = 4;
  localparam logic [11:0] CA = rsc_pkg::CAUSE_ADDR;
  localparam logic [11:0] ST = rsc_pkg::IRQ_STAT_ADDR;
  localparam logic [1:0] OK = rsc_pkg::RESP_OKAY;
  localparam logic [7:0] EXP [13] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h10, 8'h80,
    8'h80, 8'h20, 8'h04, 8'h02, 8'h08, 8'h01};
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic mon = 1, cmp = 0, cmiss = 0, vdd = 0, wdt = 0, pin = 0, go = 0;
  rsc_pkg::rsc_usb_s usb = 4'h1;
  rsc_pkg::rsc_flash_s fcmd = '0, flash;
  logic awready, wready, bvalid, arready, rvalid, allow, sysr, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] bq [$];
  logic [33:0] rq [$];
  logic [7:0] last = 8'h02;
  int err_total = 0, cmp_count = 0, hc = 0;
  // clock and hold counter
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (sysr === 1'b1) hc++;
  rsc_reset_cause #(.FLASH_IS_64K(1'b1), .HOLD_CYCLES(HOLD)) i_rsc_reset_cause (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_i(flash), .supply_mon_en_i(mon), .flash_allow_o(allow), .usb_i(usb),
    .cmp_below_i(cmp), .clock_missing_i(cmiss), .vdd_below_i(vdd), .wdt_expire_i(wdt),
    .pin_reset_i(pin), .sys_reset_o(sysr), .rst_pin_oe_o(), .irq_o(irq));
  rsc_flash_model i_rsc_flash_model (.aclk(aclk), .go(go), .cmd(fcmd), .allow(allow),
    .sys_reset(sysr), .flash(flash));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // response watcher takes the oldest note per answer
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) chk("bresp", bq.pop_front(), bresp);
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) chk("read", rq.pop_front(), {rresp, rdata});
  end
  // one bus transfer, w selects write
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    int n;
    logic ta, tw, td;
    if (w) begin
      bq.push_back(e[33:32]);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
    end else begin
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
    end
    n = 0;
    td = 0;
    while (!td && n < 100) begin
      #1;
      ta = w ? awready : arready;
      tw = wready;
      td = w ? bvalid : rvalid;
      @(posedge aclk);
      if (ta && w) awvalid <= 0;
      if (ta && !w) arvalid <= 0;
      if (tw && w) wvalid <= 0;
      n++;
    end
    bready <= 0;
    rready <= 0;
    @(posedge aclk);
    if (td !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  // raise one reset source and check the captured cause
  task automatic ev(input int k);
    int n;
    if (k > 5 && k < 11) begin
      xfer(1, CA, {24'h0, EXP[k]}, {OK, 32'h0});
      xfer(0, CA, 0, {OK, 24'h0, last});
    end
    hc = 0;
    case (k)
      0: fcmd <= {1'b1, rsc_pkg::FA_XWRITE, 16'hFC00 + 16'($urandom_range(1023)), 2'b10};
      1: fcmd <= {1'b1, rsc_pkg::FA_CREAD, 16'hFC00, 2'b00};
      2: fcmd <= {1'b1, rsc_pkg::FA_FETCH, 16'hFFFF, 2'b00};
      3: fcmd <= {1'b1, rsc_pkg::FA_CREAD, 16'h0100, 2'b01};
      4: begin
        mon <= 0;
        fcmd <= {1'b1, rsc_pkg::FA_XWRITE, 16'($urandom_range(32767)), 2'b10};
      end
      5: xfer(1, CA, 32'h10, {OK, 32'h0});
      6: usb <= 4'hD;
      7: usb <= 4'h3;
      8: cmp <= 1;
      9: cmiss <= 1;
      10: vdd <= 1;
      11: wdt <= 1;
      default: pin <= 1;
    endcase
    go <= k < 5;
    n = 0;
    while (!(hc > 0 && sysr === 1'b0) && n < 100) begin
      @(posedge aclk);
      go <= 0;
      if (hc > 0) begin
        {cmp, cmiss, vdd, wdt, pin, mon} <= 6'h01;
        usb <= 4'h1;
      end
      n++;
    end
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
    chk("hold", HOLD + 1, hc);
    chk("irq set", 1, irq);
    xfer(0, CA, 0, {OK, 24'h0, EXP[k]});
    xfer(0, ST, 0, {OK, 24'h0, EXP[k]});
    xfer(1, ST, 32'hFF, {OK, 32'h0});
    chk("irq clear", 0, irq);
    last = EXP[k];
  endtask
  // main sequence
  initial begin
    void'($urandom(14554));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    xfer(0, CA, 0, {OK, 32'h02});
    xfer(1, rsc_pkg::IRQ_MASK_ADDR, 32'hFF, {OK, 32'h0});
    hc = 0;
    xfer(1, CA, 32'h0, {OK, 32'h0});
    xfer(1, 12'h100, 32'h10, {rsc_pkg::RESP_SLVERR, 32'h0});
    xfer(0, 12'h100, 0, {rsc_pkg::RESP_SLVERR, 32'h0});
    chk("no reset", 0, hc);
    for (int k = 0; k < 13; k++) ev(k);
    wrap_up();
  end
endmodule
